/* File: src/boot_config_pkg.sv */
// shared constants and types for the boot configuration latch block
package boot_config_pkg;

   // array geometry
   localparam int NUM_LATCH_BYTES = 4;
   localparam int NUM_PORTS       = 9;
   localparam int WORD_W          = 32;
   localparam int LATCH_IDX_W     = 2;

   // register indexes; the byte address is four times the index
   localparam int IDX_W   = 3;
   localparam int IDX_LSB = 2;
   localparam logic [IDX_W-1:0] IDX_PORT_RESET_DRIVE_LOW  = 3'h0;
   localparam logic [IDX_W-1:0] IDX_PORT_RESET_DRIVE_HIGH = 3'h1;
   localparam logic [IDX_W-1:0] IDX_RESET_PIN_DEBUG       = 3'h2;
   localparam logic [IDX_W-1:0] IDX_BOOT_CLOCK_DEBUG_ECC  = 3'h3;
   localparam logic [IDX_W-1:0] IDX_APPLIED_CONFIG        = 3'h4;
   localparam logic [IDX_W-1:0] IDX_WRITE_COUNT           = 3'h5;
   localparam logic [IDX_W-1:0] IDX_LATCH_CONTROL         = 3'h6;

   // latch control register: write one to restore factory contents
   localparam int CTRL_RESTORE_BIT = 0;

   // AXI response codes
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // field positions inside the 32-bit latch image {byte3..byte0}
   localparam int RESET_PIN_BIT   = 23;
   localparam int DEBUG_ALLOW_BIT = 22;
   localparam int BOOT_SPEED_BIT  = 24;
   localparam int DPS_LSB         = 25;
   localparam int CHECK_BYTES_BIT = 27;
   localparam int PHASE_LSB       = 28;
   localparam int PORT_FIELD_W    = 2;
   // ports 0,1,2,3,4,5,6,12,15 in that order
   localparam int PORT_FIELD_LSB [NUM_PORTS] = '{0, 2, 4, 6, 8, 10, 12, 14, 16};

   // writable bits per latch byte; byte 2 bits 5:2 are reserved
   localparam logic [7:0] LATCH_WMASK [NUM_LATCH_BYTES] = '{8'hFF, 8'hFF, 8'hC3, 8'hFF};

   // factory contents
   localparam logic [3:0]  PHASE_DELAY_FACTORY = 4'h0;
   localparam logic [WORD_W-1:0] FACTORY_IMAGE =
      {PHASE_DELAY_FACTORY, 4'hA, 8'h40, 8'h00, 8'h00};

   // boot oscillator rates in MHz
   localparam logic [7:0] BOOT_OSC_SLOW_MHZ = 8'h0C;
   localparam logic [7:0] BOOT_OSC_FAST_MHZ = 8'h30;

   localparam int WRITE_COUNT_W = 16;

   typedef enum logic [1:0] {
      DRIVE_HIZ_ANALOG  = 2'h0,
      DRIVE_HIZ_DIGITAL = 2'h1,
      DRIVE_PULL_UP     = 2'h2,
      DRIVE_PULL_DOWN   = 2'h3
   } drive_mode_type;

   typedef enum logic [1:0] {
      DBG_JTAG5 = 2'h0,
      DBG_JTAG4 = 2'h1,
      DBG_SWD   = 2'h2,
      DBG_OFF   = 2'h3
   } debug_port_type;

   // per-port pin controls, one hot
   typedef struct packed {
      logic analog_hiz;
      logic digital_hiz;
      logic pull_up;
      logic pull_down;
   } pin_ctrl_type;

   // applied system configuration
   typedef struct packed {
      logic           reset_pin_function;
      logic           debug_access_allow;
      logic           boot_speed_select;
      debug_port_type debug_port_select;
      logic           check_bytes_enable;
      logic [3:0]     digital_clock_phase_delay;
   } sys_cfg_type;

endpackage : boot_config_pkg

/* File: src/config_latch_array.sv */
// four-byte nonvolatile configuration latch storage
`timescale 1ns/1ps
`default_nettype none
module config_latch_array
   import boot_config_pkg::*;
(
   // clocking
   input  wire logic                   clk,
   input  wire logic                   ce,
   // write port
   input  wire logic                   wr_en,
   input  wire logic [LATCH_IDX_W-1:0] wr_idx,
   input  wire logic [7:0]             wr_data,
   input  wire logic                   restore,
   // read port
   input  wire logic                   rd_en,
   input  wire logic [LATCH_IDX_W-1:0] rd_idx,
   output logic      [7:0]             rd_data_q,
   // whole image for the reset-time load
   output logic      [WORD_W-1:0]      image
);

   // nonvolatile: not cleared by rst, starts at factory contents
   logic [7:0] cell_q [NUM_LATCH_BYTES] = '{FACTORY_IMAGE[7:0], FACTORY_IMAGE[15:8],
                                            FACTORY_IMAGE[23:16], FACTORY_IMAGE[31:24]};

   // write or restore; restore wins since it rewrites every byte
   always_ff @(posedge clk) begin
      if (ce) begin
         if (restore) begin
            for (int i = 0; i < NUM_LATCH_BYTES; i++) begin
               cell_q[i] <= FACTORY_IMAGE[i*8 +: 8];
            end
         end else if (wr_en) begin
            cell_q[wr_idx] <= wr_data & LATCH_WMASK[wr_idx]; // reserved bits stay 0
         end
      end
   end

   // registered read port
   always_ff @(posedge clk) begin
      if (ce && rd_en) begin
         rd_data_q <= cell_q[rd_idx];
      end
   end

   // flattened view for the loader
   always_comb begin
      for (int i = 0; i < NUM_LATCH_BYTES; i++) begin
         image[i*8 +: 8] = cell_q[i];
      end
   end

endmodule : config_latch_array
`default_nettype wire

/* File: src/port_drive_decoder.sv */
// decodes one port's reset drive field into pin controls
`timescale 1ns/1ps
`default_nettype none
module port_drive_decoder
   import boot_config_pkg::*;
(
   // clocking
   input  wire logic                    clk,
   input  wire logic                    ce,
   // field in, controls out
   input  wire logic [PORT_FIELD_W-1:0] port_reset_drive_field,
   output pin_ctrl_type                 ctrl_q
);

   // every pin of the port takes this one mode
   always_ff @(posedge clk) begin
      if (ce) begin
         unique case (drive_mode_type'(port_reset_drive_field))
            DRIVE_HIZ_ANALOG:  ctrl_q <= '{analog_hiz: 1'b1, default: 1'b0};  // [RULE3]
            DRIVE_HIZ_DIGITAL: ctrl_q <= '{digital_hiz: 1'b1, default: 1'b0}; // [RULE3]
            DRIVE_PULL_UP:     ctrl_q <= '{pull_up: 1'b1, default: 1'b0};     // [RULE3]
            DRIVE_PULL_DOWN:   ctrl_q <= '{pull_down: 1'b1, default: 1'b0};   // [RULE3]
         endcase
      end
   end

endmodule : port_drive_decoder
`default_nettype wire

/* File: src/boot_config_latches.sv */
// boot configuration latches: AXI4-Lite access, reset-time load, decode
// Functional notes
// RULE1: four-byte nonvolatile array; contents configure the device on leaving reset.
// RULE2: each port's two-bit field puts all its pins in one mode.
// RULE3: field codes: analog hi-z, digital hi-z, pull-up, pull-down.
// RULE4: reset pin function bit: 0 ordinary I/O, 1 external reset input.
// RULE5: debug access bit: 1 allows debug system access, 0 blocks it.
// RULE6: boot speed bit picks 12 MHz (0) or 48 MHz (1) oscillator.
// RULE7: debug port field: 5-wire JTAG, 4-wire JTAG, SWD, or all off.
// RULE8: check bytes bit reserves extra flash for check bytes; 0 frees it.
// RULE9: four-bit field sets the digital clock phase delay.
// RULE10: programmer should limit erase/write cycles of the latch array.
// RULE11: all fields loaded before reset release, valid from first cycle after.
`timescale 1ns/1ps
`default_nettype none
module boot_config_latches
   import boot_config_pkg::*;
(
   // clock, reset, enable
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire logic               ce,
   // AXI4-Lite write address
   input  wire logic               awvalid,
   output logic                    awready,
   input  wire logic [31:0]        awaddr,
   // AXI4-Lite write data
   input  wire logic               wvalid,
   output logic                    wready,
   input  wire logic [31:0]        wdata,
   input  wire logic [3:0]         wstrb,
   // AXI4-Lite write response
   output logic                    bvalid,
   input  wire logic               bready,
   output logic      [1:0]         bresp,
   // AXI4-Lite read address
   input  wire logic               arvalid,
   output logic                    arready,
   input  wire logic [31:0]        araddr,
   // AXI4-Lite read data
   output logic                    rvalid,
   input  wire logic               rready,
   output logic      [31:0]        rdata,
   output logic      [1:0]         rresp,
   // shared reset pin
   input  wire logic               ext_reset_pin,
   output logic                    reset_pin_gpio_q,
   output logic                    ext_reset_req_q,
   // applied configuration
   output pin_ctrl_type            port_ctrl [NUM_PORTS],
   output sys_cfg_type             sys_cfg_q,
   output logic                    debug_access_en_q,
   output logic                    jtag5_en_q,
   output logic                    jtag4_en_q,
   output logic                    swd_en_q,
   output logic      [7:0]         boot_osc_mhz_q,
   output logic                    check_region_reserved_q,
   output logic      [3:0]         clock_phase_delay_q
);

   typedef enum {WR_COLLECT, WR_RESP} wr_state_type;
   typedef enum {RD_IDLE, RD_FETCH, RD_RESP} rd_state_type;

   wr_state_type             wr_state_q;
   rd_state_type             rd_state_q;
   logic                     aw_have_q;
   logic                     w_have_q;
   logic [IDX_W-1:0]         aw_idx_q;
   logic                     aw_in_range_q;
   logic [7:0]               w_byte_q;
   logic                     w_lane0_q;
   logic [1:0]               bresp_q;
   logic [IDX_W-1:0]         ar_idx_q;
   logic                     ar_in_range_q;
   logic [31:0]              rdata_q;
   logic [1:0]               rresp_q;
   logic [WRITE_COUNT_W-1:0] write_count_q;
   logic [WORD_W-1:0]        applied_q;
   logic [WORD_W-1:0]        applied_d;
   logic [WORD_W-1:0]        image;
   logic [7:0]               latch_rd_data;
   logic                     ext_sync1_q;
   logic                     ext_sync2_q;
   logic                     aw_take;
   logic                     w_take;
   logic                     ar_take;
   logic                     wr_fire;
   logic                     wr_is_latch;
   logic                     wr_is_ctrl;
   logic                     latch_wr_en;
   logic                     latch_restore;
   logic                     ar_hit;

   // handshakes: a frozen block takes nothing and offers nothing
   assign awready = ce && wr_state_q == WR_COLLECT && !aw_have_q;
   assign wready  = ce && wr_state_q == WR_COLLECT && !w_have_q;
   assign bvalid  = ce && wr_state_q == WR_RESP;
   assign arready = ce && rd_state_q == RD_IDLE;
   assign rvalid  = ce && rd_state_q == RD_RESP;
   assign bresp   = bresp_q;
   assign rdata   = rdata_q;
   assign rresp   = rresp_q;

   assign aw_take = awvalid && awready;
   assign w_take  = wvalid && wready;
   assign ar_take = arvalid && arready;

   // upper address bits must be clear for a hit
   assign ar_hit = araddr[31:IDX_LSB+IDX_W] == '0 &&
                   araddr[IDX_LSB +: IDX_W] <= IDX_LATCH_CONTROL;

   // write address and data are collected in either order
   always_ff @(posedge clk) begin
      if (rst) begin
         aw_have_q     <= 1'b0;
         aw_idx_q      <= '0;
         aw_in_range_q <= 1'b0;
      end else if (ce) begin
         if (aw_take) begin
            aw_have_q     <= 1'b1;
            aw_idx_q      <= awaddr[IDX_LSB +: IDX_W];
            aw_in_range_q <= awaddr[31:IDX_LSB+IDX_W] == '0;
         end else if (wr_fire) begin
            aw_have_q <= 1'b0;
         end
      end
   end

   // only byte lane 0 carries register write data; wider lanes of wdata are dropped
   always_ff @(posedge clk) begin
      if (rst) begin
         w_have_q  <= 1'b0;
         w_byte_q  <= '0;
         w_lane0_q <= 1'b0;
      end else if (ce) begin
         if (w_take) begin
            w_have_q  <= 1'b1;
            w_byte_q  <= wdata[7:0];
            w_lane0_q <= wstrb[0];
         end else if (wr_fire) begin
            w_have_q <= 1'b0;
         end
      end
   end

   // write decode once both halves are held
   assign wr_fire     = wr_state_q == WR_COLLECT && aw_have_q && w_have_q;
   assign wr_is_latch = aw_in_range_q && aw_idx_q <= IDX_BOOT_CLOCK_DEBUG_ECC;
   assign wr_is_ctrl  = aw_in_range_q && aw_idx_q == IDX_LATCH_CONTROL;
   // new latch contents only take effect at the next reset
   assign latch_wr_en   = ce && wr_fire && wr_is_latch && w_lane0_q; // [RULE1]
   assign latch_restore = ce && wr_fire && wr_is_ctrl && w_lane0_q &&
                          w_byte_q[CTRL_RESTORE_BIT];

   // write channel sequencing; read-only or unmapped writes get SLVERR
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_state_q <= WR_COLLECT;
         bresp_q    <= RESP_OKAY;
      end else if (ce) begin
         unique case (wr_state_q)
            WR_COLLECT: begin
               if (wr_fire) begin
                  wr_state_q <= WR_RESP;
                  bresp_q    <= (wr_is_latch || wr_is_ctrl) ? RESP_OKAY : RESP_SLVERR;
               end
            end
            WR_RESP: begin
               if (bready) begin
                  wr_state_q <= WR_COLLECT;
               end
            end
         endcase
      end
   end

   // wear counter so software can police erase/write cycles; saturates
   always_ff @(posedge clk) begin
      if (rst) begin
         write_count_q <= '0;
      end else if (ce && (latch_wr_en || latch_restore) && ~&write_count_q) begin
         write_count_q <= write_count_q + 1'b1; // [RULE10]
      end
   end

   // read channel: fetch one cycle, then answer
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_state_q    <= RD_IDLE;
         ar_idx_q      <= '0;
         ar_in_range_q <= 1'b0;
         rdata_q       <= '0;
         rresp_q       <= RESP_OKAY;
      end else if (ce) begin
         unique case (rd_state_q)
            RD_IDLE: begin
               if (ar_take) begin
                  rd_state_q    <= RD_FETCH;
                  ar_idx_q      <= araddr[IDX_LSB +: IDX_W];
                  ar_in_range_q <= ar_hit;
               end
            end
            RD_FETCH: begin
               rd_state_q <= RD_RESP;
               rresp_q    <= ar_in_range_q ? RESP_OKAY : RESP_SLVERR;
               rdata_q    <= '0;
               if (ar_in_range_q) begin
                  if (ar_idx_q <= IDX_BOOT_CLOCK_DEBUG_ECC) begin
                     rdata_q[7:0] <= latch_rd_data;
                  end else if (ar_idx_q == IDX_APPLIED_CONFIG) begin
                     rdata_q <= applied_q;
                  end else if (ar_idx_q == IDX_WRITE_COUNT) begin
                     rdata_q[WRITE_COUNT_W-1:0] <= write_count_q;
                  end
               end
            end
            RD_RESP: begin
               if (rready) begin
                  rd_state_q <= RD_IDLE;
               end
            end
         endcase
      end
   end

   // the nonvolatile store itself
   config_latch_array u_array (
      .clk       (clk),
      .ce        (ce),
      .wr_en     (latch_wr_en),
      .wr_idx    (aw_idx_q[LATCH_IDX_W-1:0]),
      .wr_data   (w_byte_q),
      .restore   (latch_restore),
      .rd_en     (ar_take),
      .rd_idx    (araddr[IDX_LSB +: LATCH_IDX_W]),
      .rd_data_q (latch_rd_data),
      .image     (image)
   );

   // while rst is held the image flows through, so every decoded
   // output already carries it at the first edge after release
   assign applied_d = rst ? image : applied_q; // [RULE1] [RULE11]

   always_ff @(posedge clk) begin
      if (ce) begin
         applied_q <= applied_d; // [RULE11]
      end
   end

   // one decoder per port; a field covers the whole port
   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      port_drive_decoder u_dec (
         .clk                    (clk),
         .ce                     (ce),
         .port_reset_drive_field (applied_d[PORT_FIELD_LSB[p] +: PORT_FIELD_W]), // [RULE2]
         .ctrl_q                 (port_ctrl[p])
      );
   end

   // system fields as a struct
   always_ff @(posedge clk) begin
      if (ce) begin
         sys_cfg_q.reset_pin_function        <= applied_d[RESET_PIN_BIT];
         sys_cfg_q.debug_access_allow        <= applied_d[DEBUG_ALLOW_BIT];
         sys_cfg_q.boot_speed_select         <= applied_d[BOOT_SPEED_BIT];
         sys_cfg_q.debug_port_select         <= debug_port_type'(applied_d[DPS_LSB +: 2]);
         sys_cfg_q.check_bytes_enable        <= applied_d[CHECK_BYTES_BIT];
         sys_cfg_q.digital_clock_phase_delay <= applied_d[PHASE_LSB +: 4];
      end
   end

   // reset pin role chosen once per reset
   always_ff @(posedge clk) begin
      if (ce) begin
         reset_pin_gpio_q <= !applied_d[RESET_PIN_BIT]; // [RULE4]
      end
   end

   // pin is asynchronous to clk, so two flops before use
   always_ff @(posedge clk) begin
      if (rst) begin
         ext_sync1_q <= 1'b0;
         ext_sync2_q <= 1'b0;
      end else if (ce) begin
         ext_sync1_q <= ext_reset_pin;
         ext_sync2_q <= ext_sync1_q;
      end
   end

   // the pin only requests a reset when configured as one
   always_ff @(posedge clk) begin
      if (rst) begin
         ext_reset_req_q <= 1'b0;
      end else if (ce) begin
         ext_reset_req_q <= applied_q[RESET_PIN_BIT] && ext_sync2_q; // [RULE4]
      end
   end

   // debug access and pin protocol; pins stay off when access is blocked
   always_ff @(posedge clk) begin
      if (ce) begin
         debug_access_en_q <= applied_d[DEBUG_ALLOW_BIT]; // [RULE5]
         jtag5_en_q <= applied_d[DEBUG_ALLOW_BIT] &&
                       applied_d[DPS_LSB +: 2] == DBG_JTAG5; // [RULE5] [RULE7]
         jtag4_en_q <= applied_d[DEBUG_ALLOW_BIT] &&
                       applied_d[DPS_LSB +: 2] == DBG_JTAG4; // [RULE7]
         swd_en_q   <= applied_d[DEBUG_ALLOW_BIT] &&
                       applied_d[DPS_LSB +: 2] == DBG_SWD;   // [RULE7]
      end
   end

   // boot clock rate, check byte region and clock phase
   always_ff @(posedge clk) begin
      if (ce) begin
         boot_osc_mhz_q <= applied_d[BOOT_SPEED_BIT] ? BOOT_OSC_FAST_MHZ
                                                     : BOOT_OSC_SLOW_MHZ; // [RULE6]
         check_region_reserved_q <= applied_d[CHECK_BYTES_BIT]; // [RULE8]
         clock_phase_delay_q     <= applied_d[PHASE_LSB +: 4];  // [RULE9]
      end
   end

endmodule : boot_config_latches
`default_nettype wire

/* File: tb/boot_config_latches_properties.sv */
// assertions on the boot configuration latch block ports
`timescale 1ns/1ps
`default_nettype none
module boot_config_latches_properties
   import boot_config_pkg::*;
(
   // clock and reset
   input wire logic         clk,
   input wire logic         rst,
   input wire logic         ce,
   // read handshake
   input wire logic         arvalid,
   input wire logic         arready,
   input wire logic         rvalid,
   // reset pin and applied configuration
   input wire logic         ext_reset_pin,
   input wire logic         reset_pin_gpio_q,
   input wire logic         ext_reset_req_q,
   input wire pin_ctrl_type port_ctrl [NUM_PORTS],
   input wire sys_cfg_type  sys_cfg_q,
   input wire logic         debug_access_en_q,
   input wire logic         jtag5_en_q,
   input wire logic         jtag4_en_q,
   input wire logic         swd_en_q,
   input wire logic [7:0]   boot_osc_mhz_q,
   input wire logic         check_region_reserved_q,
   input wire logic [3:0]   clock_phase_delay_q
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);

   // steps of a read and of a held external reset request
   sequence read_taken;
      arvalid && arready && ce;
   endsequence
   sequence two_edge_answer;
      ##1 !rvalid ##1 rvalid;
   endsequence
   sequence pin_held;
      (sys_cfg_q.reset_pin_function && ext_reset_pin) [*4];
   endsequence

   read_answer_a: assert property (read_taken |-> two_edge_answer)
      else $error("read answer not two edges after address");
   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      drive_onehot_a: assert property ($onehot(port_ctrl[p]))
         else $error("port controls not one hot");
   end
   gpio_function_a: assert property (reset_pin_gpio_q == !sys_cfg_q.reset_pin_function)
      else $error("shared pin role disagrees with function bit");
   ext_request_a: assert property (pin_held |-> ext_reset_req_q)
      else $error("external reset request missing");
   ext_blocked_a: assert property (!sys_cfg_q.reset_pin_function |-> !ext_reset_req_q)
      else $error("reset request while pin is ordinary io");
   debug_blocked_a: assert property (!debug_access_en_q |-> !(jtag5_en_q || jtag4_en_q || swd_en_q))
      else $error("debug pins on while access blocked");
   swd_select_a: assert property (debug_access_en_q && sys_cfg_q.debug_port_select == DBG_SWD
      |-> swd_en_q && !jtag4_en_q && !jtag5_en_q)
      else $error("wrong debug port for serial wire");
   boot_rate_a: assert property (boot_osc_mhz_q == (sys_cfg_q.boot_speed_select ? 8'h30 : 8'h0C))
      else $error("boot oscillator rate wrong");
   check_bytes_a: assert property (check_region_reserved_q == sys_cfg_q.check_bytes_enable)
      else $error("check byte region flag wrong");
   phase_delay_a: assert property (clock_phase_delay_q == sys_cfg_q.digital_clock_phase_delay)
      else $error("phase delay output wrong");
   config_frozen_a: assert property (!rst |=> $stable(sys_cfg_q))
      else $error("applied configuration moved outside reset");
endmodule : boot_config_latches_properties

bind boot_config_latches boot_config_latches_properties chk_u (
   .clk, .rst, .ce, .arvalid, .arready, .rvalid, .ext_reset_pin, .reset_pin_gpio_q,
   .ext_reset_req_q, .port_ctrl, .sys_cfg_q, .debug_access_en_q, .jtag5_en_q,
   .jtag4_en_q, .swd_en_q, .boot_osc_mhz_q, .check_region_reserved_q, .clock_phase_delay_q
);
`default_nettype wire

/* File: tb/boot_config_latches_tb.sv */
// self-checking bench for the boot configuration latch block
`timescale 1ns/1ps
`default_nettype none
module boot_config_latches_tb
   import boot_config_pkg::*;
;
   // design ports and bench state
   logic         clk, rst, ce, ext_reset_pin;
   logic         awvalid, awready, wvalid, wready, bvalid, bready;
   logic         arvalid, arready, rvalid, rready;
   logic [31:0]  awaddr, wdata, araddr, rdata, data;
   logic [3:0]   wstrb;
   logic [1:0]   bresp, rresp, resp;
   logic         reset_pin_gpio_q, ext_reset_req_q, debug_access_en_q;
   logic         jtag5_en_q, jtag4_en_q, swd_en_q, check_region_reserved_q;
   logic [7:0]   boot_osc_mhz_q;
   logic [3:0]   clock_phase_delay_q;
   pin_ctrl_type port_ctrl [NUM_PORTS];
   sys_cfg_type  sys_cfg_q;
   int           fail_count, compares;

   boot_config_latches dut_u (
      .clk, .rst, .ce, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
      .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
      .rresp, .ext_reset_pin, .reset_pin_gpio_q, .ext_reset_req_q, .port_ctrl, .sys_cfg_q,
      .debug_access_en_q, .jtag5_en_q, .jtag4_en_q, .swd_en_q, .boot_osc_mhz_q,
      .check_region_reserved_q, .clock_phase_delay_q
   );

   // 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic check(input logic [31:0] got, exp, input string what);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check

   task automatic conclude;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : conclude

   // ends just before the first edge after release, where outputs must already hold
   task automatic do_reset;
      @(posedge clk);
      rst <= 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
   endtask : do_reset

   function automatic logic [31:0] adr(input int i);
      return 32'(i * 4);
   endfunction : adr

   // readys are judged at the falling edge, so the rising edge never races the design
   task automatic axi_write(input logic [31:0] a, input logic [7:0] d, input logic [3:0] s);
      logic aw_hit, w_hit;
      aw_hit = 1'b0;
      w_hit = 1'b0;
      @(posedge clk);
      awaddr  <= a;
      wdata   <= {24'h0, d};
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!(aw_hit && w_hit)) begin
         @(negedge clk);
         aw_hit = aw_hit || (awready === 1'b1);
         w_hit  = w_hit || (wready === 1'b1);
         @(posedge clk);
         if (aw_hit) awvalid <= 1'b0;
         if (w_hit) wvalid <= 1'b0;
      end
      do @(negedge clk); while (bvalid !== 1'b1);
      resp = bresp;
      @(posedge clk);
      bready <= 1'b0;
   endtask : axi_write

   task automatic axi_read(input logic [31:0] a);
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(negedge clk); while (arready !== 1'b1);
      @(posedge clk);
      arvalid <= 1'b0;
      do @(negedge clk); while (rvalid !== 1'b1);
      data = rdata;
      resp = rresp;
      @(posedge clk);
      rready <= 1'b0;
   endtask : axi_read

   // decode an image {r3,r2,r1,r0} by hand and compare every applied output
   task automatic check_outputs(input logic [31:0] img);
      for (int p = 0; p < NUM_PORTS; p++) begin
         check(32'(port_ctrl[p]), 32'(4'b1000 >> img[2*p +: 2]), "drive");
      end
      check(32'(reset_pin_gpio_q), 32'(!img[23]), "pin role");
      check(32'(debug_access_en_q), 32'(img[22]), "debug allow");
      check(32'(boot_osc_mhz_q), img[24] ? 32'h30 : 32'h0C, "osc");
      check(32'({jtag5_en_q, jtag4_en_q, swd_en_q}),
            img[22] ? 32'(3'b100 >> img[26:25]) : 32'h0, "debug pins");
      check(32'(check_region_reserved_q), 32'(img[27]), "ecc region");
      check(32'(clock_phase_delay_q), 32'(img[31:28]), "phase");
      check(32'(sys_cfg_q), 32'({img[23:22], img[24], img[26:25], img[27], img[31:28]}),
            "sys cfg");
      axi_read(adr(4));
      check(data, img, "applied image");
   endtask : check_outputs

   task automatic t_defaults;
      do_reset;
      check_outputs(32'h0A400000);
   endtask : t_defaults

   // new contents stay latent until the next reset; reserved bits read zero
   task automatic t_program;
      axi_write(adr(0), 8'hE4, 4'hF);
      axi_write(adr(1), 8'h1B, 4'hF);
      axi_write(adr(2), 8'hFE, 4'hF);
      axi_write(adr(3), 8'h55, 4'hF);
      check(32'(resp), 32'(RESP_OKAY), "write resp");
      axi_read(adr(2));
      check(data, 32'h000000C2, "reserved bits");
      check_outputs(32'h0A400000);
      do_reset;
      check_outputs(32'h55C21BE4);
   endtask : t_program

   // every debug port code with access allowed and blocked
   task automatic t_debug;
      for (int a = 1; a >= 0; a--) begin
         for (int d = 0; d < 4; d++) begin
            if (d == 0) axi_write(adr(2), 8'(a << 6), 4'hF); // few rewrites
            axi_write(adr(3), 8'(8'h08 | (d << 1)), 4'hF);
            do_reset;
            check_outputs({8'(8'h08 | (d << 1)), 8'(a << 6), 16'h1BE4});
         end
      end
   endtask : t_debug

   task automatic t_pin;
      axi_write(adr(2), 8'h80, 4'hF);
      do_reset;
      @(posedge clk);
      ext_reset_pin <= 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk);
      check(32'(ext_reset_req_q), 32'h0, "request early");
      @(negedge clk);
      check(32'(ext_reset_req_q), 32'h1, "request");
      axi_write(adr(2), 8'h00, 4'hF);
      do_reset;
      repeat (5) @(negedge clk);
      check(32'(ext_reset_req_q), 32'h0, "request as io");
      @(posedge clk);
      ext_reset_pin <= 1'b0;
   endtask : t_pin

   task automatic t_errors;
      axi_write(adr(7), 8'hFF, 4'hF);
      check(32'(resp), 32'(RESP_SLVERR), "unmapped write");
      axi_write(adr(4), 8'hFF, 4'hF);
      check(32'(resp), 32'(RESP_SLVERR), "read-only write");
      axi_read(32'h00000020);
      check(data, 32'h0, "unmapped data");
      check(32'(resp), 32'(RESP_SLVERR), "unmapped read");
      axi_write(adr(0), 8'h77, 4'h0);
      axi_read(adr(0));
      check(data, 32'h000000E4, "masked lane");
      axi_write(adr(6), 8'h01, 4'hF);
      axi_read(adr(3));
      check(data, 32'h0000000A, "restored");
      axi_read(adr(5));
      check(data, 32'h1, "wear count");
   endtask : t_errors

   // main sequence; clock enable stays high throughout
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready, ext_reset_pin} = '0;
      {awaddr, wdata, araddr, wstrb} = '0;
      t_defaults;
      t_program;
      t_debug;
      t_pin;
      t_errors;
      conclude;
   end

   // hang guard, far beyond the few hundred cycles the run needs
   initial begin
      #200us;
      fail_count++;
      $display("BAD %0t watchdog expired", $time);
      conclude;
   end
endmodule : boot_config_latches_tb
`default_nettype wire
